// ===== logic/fcv_checker.sv
/*
  Frame checksum video checker. Takes per-frame measurements (mode, rate and three
  component checksums) as a one-cycle frame strobe and produces a pass/fail verdict.
  Assumes frame measurements arrive synchronous to core_clk from the capture logic.
*/
`timescale 1ns/1ns
module fcv_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Frame measurements
  input wire logic frame_valid,
  input wire logic [15:0] frame_width,
  input wire logic [15:0] frame_height,
  input wire logic [7:0] pixel_bit_depth,
  input wire logic [31:0] frame_rate_mhz,
  input wire logic [3:0] frame_format,
  input wire logic [15:0] crc_r,
  input wire logic [15:0] crc_g,
  input wire logic [15:0] crc_b,
  // Results
  output logic frame_fail,
  output logic busy,
  output logic pass,
  output logic fail,
  output logic irq
);

  typedef enum logic [2:0] {ST_IDLE, ST_MODE, ST_HUNT, ST_RUN, ST_DONE} fcv_state_e;

  localparam int LIST_AW_L = fcv_pkg::LIST_AW;
  localparam int IRQ_W_L = fcv_pkg::IRQ_W;

  fcv_state_e state;
  logic [1:0] mode;
  logic rate_en, fmt_en, capt_en;
  logic [31:0] total, bad_limit, timeout_ms, rate, rate_tol;
  logic [15:0] exp_w, exp_h;
  logic [7:0] exp_d, seq_len;
  logic [3:0] exp_fmt;
  logic [31:0] iter_target, iter_done, bad_count, checked;
  logic [LIST_AW_L-1:0] ref_sel, list_pos;
  logic [15:0] list_r [0:fcv_pkg::LIST_DEPTH-1];
  logic [15:0] list_g [0:fcv_pkg::LIST_DEPTH-1];
  logic [15:0] list_b [0:fcv_pkg::LIST_DEPTH-1];
  logic [15:0] hold_r, hold_g, hold_b;
  logic [IRQ_W_L-1:0] irq_stat, irq_mask, irq_set;
  logic [31:0] tick, ms_count;
  logic mode_ok, rate_ok, crc_hit, list_hit, first_hit, start, abort, timed_out, over_limit;
  logic [32:0] rate_diff;
  logic [31:0] next_bad;
  logic [47:0] seen_crc;

  // The seen triple is an argument, so every assign that calls this follows the frame inputs.
  function automatic logic triple_eq(input logic [47:0] seen, input logic [15:0] r,
                                     input logic [15:0] g, input logic [15:0] b);
    triple_eq = seen == {r, g, b};
  endfunction

  // ----------------------------------------------------------------
  // Comparisons
  // ----------------------------------------------------------------
  assign rate_diff = (frame_rate_mhz >= rate) ? {1'b0, frame_rate_mhz - rate}
                                              : {1'b0, rate - frame_rate_mhz};
  assign rate_ok = !rate_en || (rate_diff <= {1'b0, rate_tol});
  assign mode_ok = (frame_width == exp_w) && (frame_height == exp_h) &&
                   (pixel_bit_depth == exp_d) && rate_ok &&
                   (!fmt_en || mode != fcv_pkg::FCV_REPEAT || frame_format == exp_fmt);
  assign seen_crc = {crc_r, crc_g, crc_b};
  assign crc_hit = triple_eq(seen_crc, hold_r, hold_g, hold_b);
  assign list_hit = triple_eq(seen_crc, list_r[list_pos], list_g[list_pos], list_b[list_pos]);
  assign first_hit = triple_eq(seen_crc, list_r[0], list_g[0], list_b[0]);
  assign start = reg_wr && reg_addr == fcv_pkg::ADDR_CTRL && reg_wdata[fcv_pkg::CTRL_START];
  assign abort = reg_wr && reg_addr == fcv_pkg::ADDR_CTRL && reg_wdata[fcv_pkg::CTRL_ABORT];
  assign timed_out = busy && ms_count >= timeout_ms;
  assign next_bad = bad_count + 32'h0000_0001;
  // A miss that pushes the bad count past the limit ends single and stability runs.
  assign over_limit = !crc_hit && next_bad > bad_limit;
  assign busy = state != ST_IDLE && state != ST_DONE;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode <= 2'h0;
      rate_en <= 1'b0;
      fmt_en <= 1'b0;
      capt_en <= 1'b0;
      total <= fcv_pkg::RST_TOTAL;
      bad_limit <= fcv_pkg::RST_BAD_LIMIT;
      timeout_ms <= 32'(fcv_pkg::TIMEOUT_MS);
      exp_w <= fcv_pkg::RST_WIDTH;
      exp_h <= fcv_pkg::RST_HEIGHT;
      exp_d <= fcv_pkg::RST_DEPTH;
      rate <= 32'h0000_0000;
      rate_tol <= 32'h0000_0000;
      exp_fmt <= 4'h0;
      seq_len <= fcv_pkg::RST_SEQ_LEN;
      iter_target <= 32'h0000_0000;
      ref_sel <= '0;
      irq_mask <= '0;
    end else if (reg_wr && !busy) begin
      unique case (reg_addr)
        fcv_pkg::ADDR_CTRL: begin
          mode <= reg_wdata[fcv_pkg::CTRL_MODE_LO +: 2];
          rate_en <= reg_wdata[fcv_pkg::CTRL_RATE_EN];
          fmt_en <= reg_wdata[fcv_pkg::CTRL_FMT_EN];
          capt_en <= reg_wdata[fcv_pkg::CTRL_CAPT_EN];
        end
        fcv_pkg::ADDR_TOTAL: total <= reg_wdata;
        fcv_pkg::ADDR_BAD_LIMIT: bad_limit <= reg_wdata;
        fcv_pkg::ADDR_TIMEOUT: timeout_ms <= reg_wdata;
        fcv_pkg::ADDR_WIDTH: exp_w <= reg_wdata[15:0];
        fcv_pkg::ADDR_HEIGHT: exp_h <= reg_wdata[15:0];
        fcv_pkg::ADDR_DEPTH: exp_d <= reg_wdata[7:0];
        fcv_pkg::ADDR_RATE: rate <= reg_wdata;
        fcv_pkg::ADDR_RATE_TOL: rate_tol <= reg_wdata;
        fcv_pkg::ADDR_FORMAT: exp_fmt <= reg_wdata[3:0];
        fcv_pkg::ADDR_SEQ_LEN: seq_len <= reg_wdata[7:0];
        fcv_pkg::ADDR_ITER: iter_target <= reg_wdata;
        fcv_pkg::ADDR_REF_SEL: ref_sel <= reg_wdata[LIST_AW_L-1:0];
        fcv_pkg::ADDR_IRQ_MASK: irq_mask <= reg_wdata[IRQ_W_L-1:0];
        default: ;
      endcase
    end else if (reg_wr && reg_addr == fcv_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata[IRQ_W_L-1:0];
    end
  end

  // Reference list storage; software should keep entries unique so a hunt cannot
  // lock onto the wrong position.
  always_ff @(posedge core_clk) begin
    if (reg_wr && !busy && reg_addr == fcv_pkg::ADDR_REF_R) begin
      list_r[ref_sel] <= reg_wdata[15:0];
    end
    if (reg_wr && !busy && reg_addr == fcv_pkg::ADDR_REF_G) begin
      list_g[ref_sel] <= reg_wdata[15:0];
    end
    if (reg_wr && !busy && reg_addr == fcv_pkg::ADDR_REF_B) begin
      list_b[ref_sel] <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Timeout in milliseconds
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick <= 32'h0000_0000;
      ms_count <= 32'h0000_0000;
    end else if (!busy) begin
      tick <= 32'h0000_0000;
      ms_count <= 32'h0000_0000;
    end else if (tick == fcv_pkg::MS_CYC - 32'h0000_0001) begin
      tick <= 32'h0000_0000;
      ms_count <= ms_count + 32'h0000_0001;
    end else begin
      tick <= tick + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Check sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      pass <= 1'b0;
      fail <= 1'b0;
      bad_count <= 32'h0000_0000;
      checked <= 32'h0000_0000;
      iter_done <= 32'h0000_0000;
      list_pos <= '0;
      hold_r <= 16'h0000;
      hold_g <= 16'h0000;
      hold_b <= 16'h0000;
      frame_fail <= 1'b0;
      irq_set <= '0;
    end else begin
      frame_fail <= 1'b0;
      irq_set <= '0;
      if (start && !busy) begin
        // The mode field of this write picks the path; the mode register lands on this edge.
        if (reg_wdata[fcv_pkg::CTRL_MODE_LO +: 2] == fcv_pkg::FCV_STABLE) begin
          state <= ST_HUNT;
        end else begin
          state <= ST_MODE;
        end
        pass <= 1'b0;
        fail <= 1'b0;
        bad_count <= 32'h0000_0000;
        checked <= 32'h0000_0000;
        iter_done <= 32'h0000_0000;
        list_pos <= '0;
        hold_r <= list_r[0];
        hold_g <= list_g[0];
        hold_b <= list_b[0];
      end else if (busy && (abort || timed_out)) begin
        state <= ST_DONE;
        fail <= !(mode == fcv_pkg::FCV_REPEAT && iter_done != 32'h0000_0000 && list_pos == '0);
        pass <= mode == fcv_pkg::FCV_REPEAT && iter_done != 32'h0000_0000 && list_pos == '0;
        irq_set[fcv_pkg::IRQ_TIMEOUT] <= timed_out;
        irq_set[fcv_pkg::IRQ_DONE] <= 1'b1;
      end else if (frame_valid) begin
        unique case (state)
          ST_MODE: begin
            if (!mode_ok) begin
              state <= ST_DONE;
              fail <= 1'b1;
              irq_set[fcv_pkg::IRQ_DONE] <= 1'b1;
            end else if (mode == fcv_pkg::FCV_SINGLE) begin
              state <= ST_RUN;
              checked <= 32'h0000_0001;
              if (!crc_hit) begin
                bad_count <= next_bad;
                frame_fail <= capt_en;
                irq_set[fcv_pkg::IRQ_BAD] <= 1'b1;
              end
              if (over_limit || total <= 32'h0000_0001) begin
                state <= ST_DONE;
                fail <= over_limit;
                pass <= !over_limit;
                irq_set[fcv_pkg::IRQ_DONE] <= 1'b1;
              end
            end else if (first_hit) begin
              state <= ST_RUN;
              checked <= 32'h0000_0001;
              list_pos <= LIST_AW_L'(1);
            end else begin
              state <= ST_HUNT;
            end
          end
          ST_HUNT: begin
            if (mode == fcv_pkg::FCV_STABLE) begin
              hold_r <= crc_r;
              hold_g <= crc_g;
              hold_b <= crc_b;
              state <= ST_RUN;
            end else if (first_hit) begin
              state <= ST_RUN;
              checked <= 32'h0000_0001;
              list_pos <= LIST_AW_L'(1);
            end
          end
          ST_RUN: begin
            checked <= checked + 32'h0000_0001;
            if (mode == fcv_pkg::FCV_SINGLE || mode == fcv_pkg::FCV_STABLE) begin
              if (!crc_hit) begin
                bad_count <= next_bad;
                frame_fail <= capt_en;
                irq_set[fcv_pkg::IRQ_BAD] <= 1'b1;
              end
              if (over_limit || checked + 32'h0000_0001 >= total) begin
                state <= ST_DONE;
                fail <= over_limit;
                pass <= !over_limit;
                irq_set[fcv_pkg::IRQ_DONE] <= 1'b1;
              end
            end else if (!list_hit) begin
              state <= ST_DONE;
              fail <= 1'b1;
              bad_count <= next_bad;
              frame_fail <= capt_en;
              irq_set[fcv_pkg::IRQ_BAD] <= 1'b1;
              irq_set[fcv_pkg::IRQ_DONE] <= 1'b1;
            end else if (checked + 32'h0000_0001 >= 32'(seq_len)) begin
              if (mode == fcv_pkg::FCV_REPEAT &&
                  iter_done + 32'h0000_0001 < iter_target) begin
                iter_done <= iter_done + 32'h0000_0001;
                list_pos <= '0;
                checked <= 32'h0000_0000;
              end else begin
                iter_done <= iter_done + 32'h0000_0001;
                state <= ST_DONE;
                pass <= 1'b1;
                list_pos <= '0;
                irq_set[fcv_pkg::IRQ_DONE] <= 1'b1;
              end
            end else begin
              list_pos <= list_pos + LIST_AW_L'(1);
            end
          end
          ST_IDLE, ST_DONE: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: set wins over a write-one clear.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_stat <= '0;
    end else if (reg_wr && reg_addr == fcv_pkg::ADDR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~reg_wdata[IRQ_W_L-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        fcv_pkg::ADDR_CTRL: reg_rdata <= {26'h0, capt_en, fmt_en, rate_en, mode, 1'b0};
        fcv_pkg::ADDR_STATUS: reg_rdata <= {29'h0, fail, pass, busy};
        fcv_pkg::ADDR_IRQ_STAT: reg_rdata <= {29'h0, irq_stat};
        fcv_pkg::ADDR_IRQ_MASK: reg_rdata <= {29'h0, irq_mask};
        fcv_pkg::ADDR_TOTAL: reg_rdata <= total;
        fcv_pkg::ADDR_BAD_LIMIT: reg_rdata <= bad_limit;
        fcv_pkg::ADDR_TIMEOUT: reg_rdata <= timeout_ms;
        fcv_pkg::ADDR_WIDTH: reg_rdata <= {16'h0, exp_w};
        fcv_pkg::ADDR_HEIGHT: reg_rdata <= {16'h0, exp_h};
        fcv_pkg::ADDR_DEPTH: reg_rdata <= {24'h0, exp_d};
        fcv_pkg::ADDR_RATE: reg_rdata <= rate;
        fcv_pkg::ADDR_RATE_TOL: reg_rdata <= rate_tol;
        fcv_pkg::ADDR_FORMAT: reg_rdata <= {28'h0, exp_fmt};
        fcv_pkg::ADDR_SEQ_LEN: reg_rdata <= {24'h0, seq_len};
        fcv_pkg::ADDR_ITER: reg_rdata <= iter_target;
        fcv_pkg::ADDR_BAD_COUNT: reg_rdata <= bad_count;
        fcv_pkg::ADDR_CHECKED: reg_rdata <= checked;
        fcv_pkg::ADDR_ITER_DONE: reg_rdata <= iter_done;
        fcv_pkg::ADDR_REF_SEL: reg_rdata <= {26'h0, ref_sel};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== logic/fcv_pkg.sv
/*
  Constants for the frame checksum video checker: register offsets, reset values,
  field positions and timing counts.
  Assumes a single 10 MHz core clock and a plain address/strobe register port.
*/
package fcv_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_TOTAL = 8'h10;
  localparam logic [7:0] ADDR_BAD_LIMIT = 8'h14;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h18;
  localparam logic [7:0] ADDR_WIDTH = 8'h1C;
  localparam logic [7:0] ADDR_HEIGHT = 8'h20;
  localparam logic [7:0] ADDR_DEPTH = 8'h24;
  localparam logic [7:0] ADDR_RATE = 8'h28;
  localparam logic [7:0] ADDR_RATE_TOL = 8'h2C;
  localparam logic [7:0] ADDR_FORMAT = 8'h30;
  localparam logic [7:0] ADDR_SEQ_LEN = 8'h34;
  localparam logic [7:0] ADDR_ITER = 8'h38;
  localparam logic [7:0] ADDR_BAD_COUNT = 8'h3C;
  localparam logic [7:0] ADDR_CHECKED = 8'h40;
  localparam logic [7:0] ADDR_ITER_DONE = 8'h44;
  localparam logic [7:0] ADDR_REF_SEL = 8'h48;
  localparam logic [7:0] ADDR_REF_R = 8'h4C;
  localparam logic [7:0] ADDR_REF_G = 8'h50;
  localparam logic [7:0] ADDR_REF_B = 8'h54;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_RATE_EN = 3;
  localparam int CTRL_FMT_EN = 4;
  localparam int CTRL_CAPT_EN = 5;
  localparam int CTRL_ABORT = 6;

  // Interrupt bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BAD = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_TOTAL = 32'h0000_07D0;
  localparam logic [31:0] RST_BAD_LIMIT = 32'h0000_0002;
  localparam logic [15:0] RST_WIDTH = 16'h0780;
  localparam logic [15:0] RST_HEIGHT = 16'h0438;
  localparam logic [7:0] RST_DEPTH = 8'h18;
  localparam logic [7:0] RST_SEQ_LEN = 8'h14;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint TIMEOUT_MS = 100000;
  localparam longint CLK_HZ = 10000000;
  localparam logic [31:0] TIMEOUT_CYC = 32'(TIMEOUT_MS * (CLK_HZ / 1000));
  localparam logic [31:0] MS_CYC = 32'(CLK_HZ / 1000);

  // Reference list depth.
  localparam int LIST_DEPTH = 64;
  localparam int LIST_AW = 6;

  typedef enum logic [1:0] {
    FCV_SINGLE, FCV_STABLE, FCV_SEQ, FCV_REPEAT
  } fcv_mode_e;

endpackage

// ===== sim/fcv_checker_bench.sv
/*
  Self-checking bench for the frame checksum video checker.
  Assumes the video source model and the rule checker are compiled first.
*/
`timescale 1ns/1ns
module fcv_checker_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, frame_rate_mhz;
  logic [15:0] frame_width, frame_height, crc_r, crc_g, crc_b;
  logic [7:0] pixel_bit_depth;
  logic [3:0] frame_format;
  logic frame_valid, frame_fail, busy, pass, fail, irq;
  logic [15:0] vw = 16'h0780;
  logic [31:0] vr = 32'h0000_EA60;
  logic [3:0] vf = 4'h0;
  int gap = 0;
  int errors = 0;
  int total_checks = 0;
  always #50 core_clk = ~core_clk;
  fcv_checker uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_valid(frame_valid), .frame_width(frame_width), .frame_height(frame_height),
    .pixel_bit_depth(pixel_bit_depth), .frame_rate_mhz(frame_rate_mhz),
    .frame_format(frame_format), .crc_r(crc_r), .crc_g(crc_g), .crc_b(crc_b),
    .frame_fail(frame_fail), .busy(busy), .pass(pass), .fail(fail), .irq(irq));
  fcv_video_src src (.core_clk(core_clk), .frame_valid(frame_valid),
    .frame_width(frame_width), .frame_height(frame_height),
    .pixel_bit_depth(pixel_bit_depth), .frame_rate_mhz(frame_rate_mhz),
    .frame_format(frame_format), .crc_r(crc_r), .crc_g(crc_g), .crc_b(crc_b));
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask
  task automatic frm(input logic [15:0] r, input logic [15:0] g, input logic [15:0] b);
    src.send({vw, 16'h0438, 8'h18, vr, vf, r, g, b}, gap);
    #1;
  endtask
  task automatic ent(input int k);
    frm(16'h1000 + 16'(k), 16'h2000 + 16'(k), 16'h3000 + 16'(k));
  endtask
  task automatic load_ref(input int k);
    wr(fcv_pkg::ADDR_REF_SEL, 32'(k));
    wr(fcv_pkg::ADDR_REF_R, 32'h1000 + 32'(k));
    wr(fcv_pkg::ADDR_REF_G, 32'h2000 + 32'(k));
    wr(fcv_pkg::ADDR_REF_B, 32'h3000 + 32'(k));
  endtask
  task automatic feed(input int base, input int len, input int lim);
    int i;
    i = 0;
    #1;
    while (busy === 1'b1 && i < lim) begin
      ent(base + i % len);
      i++;
    end
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    #1;
    while (busy === 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(fcv_pkg::ADDR_TOTAL, 32'h0000_07D0, "total");
    rdc(fcv_pkg::ADDR_BAD_LIMIT, 32'h0000_0002, "limit");
    rdc(fcv_pkg::ADDR_TIMEOUT, 32'h0001_86A0, "timeout");
    rdc(fcv_pkg::ADDR_WIDTH, 32'h0000_0780, "width");
    rdc(fcv_pkg::ADDR_HEIGHT, 32'h0000_0438, "height");
    rdc(fcv_pkg::ADDR_DEPTH, 32'h0000_0018, "depth");
    rdc(fcv_pkg::ADDR_SEQ_LEN, 32'h0000_0014, "seq len");
    rdc(8'hFC, 32'h0000_0000, "unmapped");
  endtask
  task automatic t_single_bad;
    load_ref(0);
    wr(fcv_pkg::ADDR_TOTAL, 32'h0000_0005);
    wr(fcv_pkg::ADDR_BAD_LIMIT, 32'h0000_0001);
    wr(fcv_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0021);
    ent(0);
    frm(16'h7777, 16'h7777, 16'h7777);
    chk("frame flag", 32'(frame_fail), 32'h1);
    @(posedge core_clk);
    #1;
    chk("irq bad", 32'(irq), 32'h1);
    frm(16'h7777, 16'h7777, 16'h7777);
    wait_idle(20);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0004, "status");
    rdc(fcv_pkg::ADDR_BAD_COUNT, 32'h0000_0002, "bad count");
    wr(fcv_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    #1;
    chk("irq clear", 32'(irq), 32'h0);
    ent(0);
    rdc(fcv_pkg::ADDR_BAD_COUNT, 32'h0000_0002, "held count");
  endtask
  task automatic t_single_rate;
    wr(fcv_pkg::ADDR_TOTAL, 32'h0000_0003);
    wr(fcv_pkg::ADDR_RATE, 32'h0000_EA60);
    wr(fcv_pkg::ADDR_RATE_TOL, 32'h0000_0064);
    vr = 32'h0000_EAB2;
    gap = 3;
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0009);
    feed(0, 1, 6);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0002, "rate in");
    rdc(fcv_pkg::ADDR_CHECKED, 32'h0000_0003, "checked");
    vr = 32'h0000_EB28;
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0009);
    feed(0, 1, 6);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0004, "rate out");
    gap = 0;
  endtask
  task automatic t_mode_stable;
    vw = 16'h0500;
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0001);
    feed(0, 1, 6);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0004, "mode bad");
    load_ref(2);
    wr(fcv_pkg::ADDR_TOTAL, 32'h0000_0004);
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0003);
    ent(2);
    ent(1);
    feed(2, 1, 8);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0002, "stable");
    rdc(fcv_pkg::ADDR_BAD_COUNT, 32'h0000_0001, "stable bad");
    vw = 16'h0780;
  endtask
  task automatic t_sequence;
    load_ref(0);
    load_ref(1);
    wr(fcv_pkg::ADDR_SEQ_LEN, 32'h0000_0003);
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0005);
    ent(5);
    ent(1);
    feed(0, 3, 6);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0002, "seq");
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0005);
    ent(0);
    ent(2);
    feed(0, 3, 4);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0004, "seq skip");
  endtask
  task automatic t_repeat;
    wr(fcv_pkg::ADDR_ITER, 32'h0000_0002);
    wr(fcv_pkg::ADDR_FORMAT, 32'h0000_0003);
    vf = 4'h3;
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0017);
    feed(0, 3, 12);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0002, "repeat");
    rdc(fcv_pkg::ADDR_ITER_DONE, 32'h0000_0002, "iterations");
    vf = 4'h1;
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0017);
    feed(0, 3, 4);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0004, "format");
  endtask
  task automatic t_timeout;
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0005);
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0040);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0004, "aborted");
    wr(fcv_pkg::ADDR_TIMEOUT, 32'h0000_0001);
    wr(fcv_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
    wr(fcv_pkg::ADDR_CTRL, 32'h0000_0005);
    wait_idle(10500);
    rdc(fcv_pkg::ADDR_STATUS, 32'h0000_0004, "timed out");
    chk("irq timeout", 32'(irq), 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_single_bad();
    t_single_rate();
    t_mode_stable();
    t_sequence();
    t_repeat();
    t_timeout();
    end_sim();
  end
  // The longest wait is the shortened timeout; the rest needs a few hundred cycles.
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    end_sim();
  end
endmodule
bind fcv_checker fcv_rule_checker chk_i (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .frame_valid(frame_valid), .frame_fail(frame_fail), .busy(busy), .pass(pass),
  .fail(fail));

// ===== sim/fcv_checker_checker.sv
/*
  Port-level assertions for the frame checksum video checker.
  Assumes it is bound to the checker instance and sees its ports only.
*/
`timescale 1ns/1ns
module fcv_rule_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Frames and results
  input wire logic frame_valid,
  input wire logic frame_fail,
  input wire logic busy,
  input wire logic pass,
  input wire logic fail
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic start_wr;
  // Any control write may start a run, so the verdict may only drop then.
  assign start_wr = reg_wr && (reg_addr == fcv_pkg::ADDR_CTRL);
  rdata_quiet_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("rdata stray");
  verdict_excl_a:
    assert property (!(pass && fail)) else $error("pass and fail together");
  run_no_verdict_a:
    assert property (busy |-> !pass && !fail) else $error("verdict while running");
  pass_hold_a:
    assert property (pass && !start_wr |=> pass) else $error("pass dropped");
  fail_hold_a:
    assert property (fail && !start_wr |=> fail) else $error("fail dropped");
  end_verdict_a:
    assert property ($fell(busy) && !$past(reg_wr) |-> pass || fail) else $error("no verdict");
  verdict_from_run_a:
    assert property ($rose(pass) || $rose(fail) |-> $past(busy)) else $error("verdict idle");
  flag_cause_a:
    assert property (frame_fail |-> $past(frame_valid) && $past(busy)) else $error("stray flag");
  idle_ignore_a:
    assert property (frame_valid && !busy && !reg_wr |=> $stable(pass) && $stable(fail))
      else $error("idle frame used");
endmodule

// ===== sim/fcv_video_src.sv
/*
  Video source model: delivers one measured frame per call as a one-cycle strobe.
  Assumes the bench calls send from its own process, clocked by core_clk.
*/
`timescale 1ns/1ns
module fcv_video_src (
  // Clock
  input wire logic core_clk,
  // Frame measurements
  output logic frame_valid,
  output logic [15:0] frame_width,
  output logic [15:0] frame_height,
  output logic [7:0] pixel_bit_depth,
  output logic [31:0] frame_rate_mhz,
  output logic [3:0] frame_format,
  output logic [15:0] crc_r,
  output logic [15:0] crc_g,
  output logic [15:0] crc_b
);
  initial begin
    frame_valid = 1'b0;
    {frame_width, frame_height, pixel_bit_depth, frame_rate_mhz} = '1;
    {frame_format, crc_r, crc_g, crc_b} = '1;
  end
  task automatic send(input logic [123:0] meas, input int gap);
    @(posedge core_clk);
    frame_valid <= 1'b1;
    {frame_width, frame_height, pixel_bit_depth, frame_rate_mhz} <= meas[123:52];
    {frame_format, crc_r, crc_g, crc_b} <= meas[51:0];
    @(posedge core_clk);
    frame_valid <= 1'b0;
    // Lines go to the inverse between frames, so a stale value never passes as valid.
    {frame_width, frame_height, pixel_bit_depth, frame_rate_mhz} <= ~meas[123:52];
    {frame_format, crc_r, crc_g, crc_b} <= ~meas[51:0];
    repeat (gap) @(posedge core_clk);
  endtask
endmodule
